// ### logic/ps_cfg_pkg.sv
// Purpose: Constants and types for the passive serial config port.
// Assumes: CLOCK runs at 20 MHz; all pins arrive asynchronously.
// Notes: Cycle counts derive from the printed times and the rate.
//
// Notes on behaviour
// - Request rise starts load; status released first
// - Raise config_done on success, then initialize
// - Ignore config_clock edges once configured
// - Stopped clock pauses load, state kept
// - Detected error drives status_n low
// - Auto-restart releases status_n after timeout
// - Configured device enables next chain device
// - Shared done: all initialize together
// - Any error on shared status halts chain
// - Request fall: done, status low within 200 ns
// - Request rise: status released within 4 us
// - Status error pulse 10-40 us or 1 us
// - User mode 2-8 us or 0.6-2 us after done
// - Power-up status low at most 5 us

package ps_cfg_pkg;

    // ------------------------------------------------------------
    // Clock rate and printed times
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int CLEAR_NS = 1000;
    localparam int STLOW_V40_US = 10;
    localparam int STLOW_V10_US = 1;
    localparam int UM_V40_US = 2;
    localparam int UM_V10_NS = 600;
    localparam logic [15:0] CLEAR_CYC = 16'((CLEAR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] STLOW_V40_CYC = 16'((STLOW_V40_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] STLOW_V10_CYC = 16'((STLOW_V10_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] UM_V40_CYC = 16'((UM_V40_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] UM_V10_CYC = 16'((UM_V10_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] INIT_V40_CLKS = 16'h0028;
    localparam logic [15:0] INIT_V10_CLKS = 16'h000A;

    // ------------------------------------------------------------
    // Bitstream layout
    // ------------------------------------------------------------
    localparam int CFG_BYTES = 16;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] LAST_IDX = 4'hF;
    localparam logic [7:0] PREAMBLE = 8'hA5;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // Synchroniser bit positions
    // ------------------------------------------------------------
    localparam int SY_W = 10;
    localparam int B_REQ = 0;
    localparam int B_CCLK = 1;
    localparam int B_DATA = 2;
    localparam int B_CE = 3;
    localparam int B_STAT = 4;
    localparam int B_DONE = 5;
    localparam int B_UCLK = 6;
    localparam int B_V40 = 7;
    localparam int B_AUTO = 8;
    localparam int B_EXT = 9;
    localparam logic [SY_W-1:0] SY_RST = 10'h000;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_HOLD = 7'h01,
        S_CLEAR = 7'h02,
        S_LOAD = 7'h04,
        S_ERR = 7'h08,
        S_WDONE = 7'h10,
        S_START = 7'h20,
        S_USER = 7'h40
    } state_e;

    typedef struct packed {
        state_e st;
        logic [SY_W-1:0] s1;
        logic [SY_W-1:0] s2;
        logic cprev;
        logic uprev;
        logic [15:0] cnt;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [IDX_W-1:0] idx;
        logic [7:0] xsum;
        logic err_own;
        logic st_low;
        logic done_low;
        logic ceo_n;
        logic user;
        logic [7:0] rd;
    } regs_s;

endpackage

// ### logic/ps_cfg_port.sv
// Purpose: Device end of a passive serial configuration port.
// Assumes: Open-drain pins resolved outside; pins are asynchronous.
// Notes: config_clock is sampled and its edges found on CLOCK.
//        Loading starts only once the freed status pin reads high.
`timescale 1ns/10ps
`default_nettype none

module ps_cfg_port
    import ps_cfg_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CONFIG_REQUEST_N,
    input wire logic CONFIG_CLOCK,
    input wire logic CONFIG_DATA,
    input wire logic CHAIN_ENABLE_IN_N,
    input wire logic STATUS_N_I,
    output logic STATUS_N_O,
    output logic STATUS_N_OE,
    input wire logic CONFIG_DONE_I,
    output logic CONFIG_DONE_O,
    output logic CONFIG_DONE_OE,
    output logic CHAIN_ENABLE_OUT_N,
    input wire logic USER_STARTUP_CLOCK,
    input wire logic VARIANT_40,
    input wire logic AUTO_RESTART,
    input wire logic EXT_STARTUP,
    output logic INIT_COMPLETE,
    input wire logic [IDX_W-1:0] CFG_RD_ADDR,
    output logic [7:0] CFG_RD_DATA
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Pick a count by device variant
    function automatic logic [15:0] pick(input logic v40,
                                         input logic [15:0] a,
                                         input logic [15:0] b);
        pick = v40 ? a : b;
    endfunction

    // Step a counter by one
    function automatic logic [15:0] bump(input logic [15:0] c);
        bump = c + 16'h0001;
    endfunction

    // Own error pulse done and auto-restart allowed
    function automatic logic auto_restart_ok(input regs_s r, input logic big);
        auto_restart_ok = r.s2[B_AUTO]
            && (r.cnt >= pick(big, STLOW_V40_CYC, STLOW_V10_CYC) - 16'h0001);
    endfunction

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    // Registered state and its next value
    regs_s q;
    regs_s d;

    // Byte store and its write port
    logic [7:0] store_q [CFG_BYTES];
    logic wr_en;
    logic [7:0] wr_byte;

    // Views derived from the synchronised pins
    logic [7:0] new_byte;
    logic req_n;
    logic cclk_rise;
    logic uclk_rise;
    logic v40;

    // Synchronised views of the pins
    assign req_n = q.s2[B_REQ];
    assign v40 = q.s2[B_V40];
    assign cclk_rise = q.s2[B_CCLK] && !q.cprev;
    assign uclk_rise = q.s2[B_UCLK] && !q.uprev;
    assign new_byte = {q.s2[B_DATA], q.sh[7:1]};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Next-state logic
    always_comb
    begin
        d = q;
        wr_en = 1'b0;
        wr_byte = new_byte;
        // Two-stage synchronisers and edge history
        d.s1 = {EXT_STARTUP, AUTO_RESTART, VARIANT_40, USER_STARTUP_CLOCK,
                CONFIG_DONE_I, STATUS_N_I, CHAIN_ENABLE_IN_N, CONFIG_DATA,
                CONFIG_CLOCK, CONFIG_REQUEST_N};
        d.s2 = q.s1;
        d.cprev = q.s2[B_CCLK];
        d.uprev = q.s2[B_UCLK];
        // Read port, one cycle late
        d.rd = store_q[CFG_RD_ADDR];
        case (q.st)
            S_HOLD:
            begin
                // Request low: drive both open-drain pins low
                d.st_low = 1'b1;
                d.done_low = 1'b1;
                d.ceo_n = 1'b1;
                d.user = 1'b0;
                d.cnt = '0;
                if (req_n)
                begin
                    d.st = S_CLEAR;
                end
            end
            S_CLEAR:
            begin
                // Internal clear, status still low, then release
                d.cnt = bump(q.cnt);
                d.sh = '0;
                d.bitc = '0;
                d.idx = '0;
                d.xsum = '0;
                d.err_own = 1'b0;
                if (q.cnt >= CLEAR_CYC - 16'h0001)
                begin
                    d.st_low = 1'b0;
                end
                // Load only once the freed status is seen high;
                // the synchroniser lags the release by two cycles
                if (!q.st_low && q.s2[B_STAT])
                begin
                    d.st = S_LOAD;
                end
            end
            S_LOAD:
            begin
                if (!q.s2[B_STAT] && !q.st_low)
                begin
                    // Another chain member flagged an error
                    d.st = S_ERR;
                    d.cnt = '0;
                end
                else if (!q.s2[B_CE] && cclk_rise)
                begin
                    // Shift one bit in, LSB first; no edge means pause
                    d.sh = new_byte;
                    d.bitc = q.bitc + 3'h1;
                    if (q.bitc == LAST_BIT)
                    begin
                        // Byte complete: store it, fold into XOR
                        wr_en = 1'b1;
                        d.xsum = q.xsum ^ new_byte;
                        d.idx = q.idx + 4'h1;
                        // First byte must be the preamble
                        if (q.idx == '0 && new_byte != PREAMBLE)
                        begin
                            d.st = S_ERR;
                            d.err_own = 1'b1;
                            d.st_low = 1'b1;
                            d.cnt = '0;
                        end
                        // Last byte: running XOR must clear
                        else if (q.idx == LAST_IDX)
                        begin
                            if ((q.xsum ^ new_byte) != 8'h00)
                            begin
                                d.st = S_ERR;
                                d.err_own = 1'b1;
                                d.st_low = 1'b1;
                                d.cnt = '0;
                            end
                            else
                            begin
                                // Success: release done, hand on chain
                                d.st = S_WDONE;
                                d.done_low = 1'b0;
                                d.ceo_n = 1'b0;
                            end
                        end
                    end
                end
            end
            S_ERR:
            begin
                // Hold the error pulse its minimum width
                if (q.cnt != 16'hFFFF)
                begin
                    d.cnt = bump(q.cnt);
                end
                // Own fault: release after the pulse if allowed
                if (q.err_own)
                begin
                    if (auto_restart_ok(q, v40))
                    begin
                        d.st_low = 1'b0;
                        d.err_own = 1'b0;
                        d.cnt = '0;
                    end
                end
                else if (q.s2[B_STAT] && q.s2[B_AUTO])
                begin
                    // Shared status released: restart the load
                    d.st = S_CLEAR;
                    d.cnt = CLEAR_CYC - 16'h0001;
                end
            end
            S_WDONE:
            begin
                // Wait for every chain member on shared done
                if (q.s2[B_DONE])
                begin
                    d.st = S_START;
                    d.cnt = '0;
                end
            end
            S_START:
            begin
                // Startup delay; config_clock edges are ignored
                if (!q.s2[B_EXT] || uclk_rise)
                begin
                    d.cnt = bump(q.cnt);
                end
                // Internal timer or external startup edges
                if (q.s2[B_EXT] ? (q.cnt >= pick(v40, INIT_V40_CLKS, INIT_V10_CLKS))
                               : (q.cnt >= pick(v40, UM_V40_CYC, UM_V10_CYC)))
                begin
                    d.st = S_USER;
                    d.user = 1'b1;
                end
            end
            S_USER:
            begin
                // Configured: link clock edges have no effect
                d.user = 1'b1;
            end
            default:
            begin
                // Stray code: fall back to hold
                d.st = S_HOLD;
            end
        endcase
        // Request low overrides every state,
        // so a hold always wins over a transfer
        if (!req_n)
        begin
            d.st = S_HOLD;
            d.st_low = 1'b1;
            d.done_low = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // State register
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            q.st <= S_HOLD;
            q.s1 <= SY_RST;
            q.s2 <= SY_RST;
            q.cprev <= 1'b0;
            q.uprev <= 1'b0;
            q.cnt <= '0;
            q.sh <= '0;
            q.bitc <= '0;
            q.idx <= '0;
            q.xsum <= '0;
            q.err_own <= 1'b0;
            // Power-up: both open-drain pins pulled low
            q.st_low <= 1'b1;
            q.done_low <= 1'b1;
            q.ceo_n <= 1'b1;
            q.user <= 1'b0;
            q.rd <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Configuration store
    always_ff @(posedge CLOCK)
    begin
        if (wr_en)
        begin
            store_q[q.idx] <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Open-drain pins: data low, enable pulls
    assign STATUS_N_O = 1'b0;
    assign STATUS_N_OE = q.st_low;
    assign CONFIG_DONE_O = 1'b0;
    assign CONFIG_DONE_OE = q.done_low;
    // Plain levels from flip-flops
    assign CHAIN_ENABLE_OUT_N = q.ceo_n;
    assign INIT_COMPLETE = q.user;
    assign CFG_RD_DATA = q.rd;

endmodule // ps_cfg_port

`default_nettype wire

// ### testbench/ps_cfg_properties.sv
// Purpose: Port checks for the config port.
// Assumes: CLOCK at 20 MHz.
// Notes: Counters time status release and pulses.
`timescale 1ns/10ps
`default_nettype none
module ps_cfg_properties (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CONFIG_REQUEST_N,
    input wire logic CONFIG_DONE_I,
    input wire logic VARIANT_40,
    input wire logic STATUS_N_O,
    input wire logic STATUS_N_OE,
    input wire logic CONFIG_DONE_O,
    input wire logic CONFIG_DONE_OE,
    input wire logic CHAIN_ENABLE_OUT_N,
    input wire logic INIT_COMPLETE
);
    logic armed_q;
    logic err_q;
    logic [9:0] rel_q;
    logic [9:0] st_q;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Release and error pulse timers
    always_ff @(posedge CLOCK)
    begin
        armed_q <= !RST_N || !CONFIG_REQUEST_N || (armed_q && STATUS_N_OE);
        err_q <= RST_N && STATUS_N_OE && !armed_q;
        rel_q <= (RST_N && CONFIG_REQUEST_N && armed_q) ? rel_q + 10'h001 : 10'h000;
        st_q <= (RST_N && STATUS_N_OE) ? st_q + 10'h001 : 10'h000;
    end
    chk_fall_drive:
        assert property ($fell(CONFIG_REQUEST_N) |-> ##[1:4] (STATUS_N_OE && CONFIG_DONE_OE))
        else $error("no drive after request fall");
    chk_hold_low:
        assert property ((!CONFIG_REQUEST_N)[*5] |-> STATUS_N_OE && CONFIG_DONE_OE)
        else $error("pins released while request low");
    chk_rise_rel:
        assert property (!(armed_q && rel_q > 10'h050))
        else $error("status held too long after request rise");
    chk_done_chain:
        assert property ($fell(CONFIG_DONE_OE) |-> !CHAIN_ENABLE_OUT_N)
        else $error("next device not enabled");
    chk_user_wait:
        assert property ($rose(INIT_COMPLETE) |-> CONFIG_DONE_I && $past(CONFIG_DONE_I, 8))
        else $error("user mode before shared done");
    chk_user_done:
        assert property (INIT_COMPLETE && CONFIG_REQUEST_N |-> !CONFIG_DONE_OE)
        else $error("user mode with done held low");
    chk_od_low:
        assert property (STATUS_N_O == 1'b0 && CONFIG_DONE_O == 1'b0)
        else $error("open drain data not low");
    chk_err_min:
        assert property ($fell(STATUS_N_OE) && err_q |-> st_q >= (VARIANT_40 ? 200 : 20))
        else $error("error pulse too short");
endmodule // ps_cfg_properties
`default_nettype wire

// ### testbench/ps_host.sv
// Purpose: Host model driving the load pins.
// Assumes: Link clock period about 400 ns.
// Notes: Clock rests low between frames.
`timescale 1ns/10ps
`default_nettype none
module ps_host (
    output var logic config_request_n,
    output var logic config_clock,
    output var logic config_data
);
    // Idle pins
    initial
    begin
        config_request_n = 1'b1;
        config_clock = 1'b0;
        config_data = 1'b0;
    end
    // Request level
    task automatic set_req(input logic v);
        config_request_n = v;
    endtask
    // One bit, data set well before the rise
    task automatic pulse(input logic d);
        #13 config_data = d;
        #200 config_clock = 1'b1;
        #200 config_clock = 1'b0;
        config_data = ~d;
    endtask
    // One byte, low bit first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            pulse(b[i]);
    endtask
endmodule // ps_host
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the config port.
// Assumes: Host model drives the link pins.
// Notes: Random bytes from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module tb
    import ps_cfg_pkg::*;
;
    logic clk, rst_n, req_n, cclk, cdata, ce_n, st_oe, st_o, dn_oe, dn_o, ceo_n;
    logic uclk, v40, auto, ext, ic, oth_st, oth_dn;
    logic [IDX_W-1:0] ra;
    logic [7:0] rd;
    logic [7:0] bq [16];
    int fails, checked, seed, n, st_hi;
    wire st_w = !st_oe && oth_st;
    wire dn_w = !dn_oe && oth_dn;
    ps_host u_host (.config_request_n(req_n), .config_clock(cclk), .config_data(cdata));
    ps_cfg_port u_dut (.CLOCK(clk), .RST_N(rst_n), .CONFIG_REQUEST_N(req_n),
        .CONFIG_CLOCK(cclk), .CONFIG_DATA(cdata), .CHAIN_ENABLE_IN_N(ce_n),
        .STATUS_N_I(st_w), .STATUS_N_O(st_o), .STATUS_N_OE(st_oe),
        .CONFIG_DONE_I(dn_w), .CONFIG_DONE_O(dn_o), .CONFIG_DONE_OE(dn_oe),
        .CHAIN_ENABLE_OUT_N(ceo_n), .USER_STARTUP_CLOCK(uclk), .VARIANT_40(v40),
        .AUTO_RESTART(auto), .EXT_STARTUP(ext), .INIT_COMPLETE(ic),
        .CFG_RD_ADDR(ra), .CFG_RD_DATA(rd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Shortest error pulse for the variant, in clock cycles
    function automatic int min_pulse(input logic big);
        return big ? int'(STLOW_V40_CYC) : int'(STLOW_V10_CYC);
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Bounded wait for a flag, n counts cycles
    task automatic await(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(8'(n < lim), 8'h01, "wait");
    endtask
    // Stream with zero XOR unless flipped, paused midway
    task automatic load(input logic [7:0] first, input logic [7:0] flip);
        logic [7:0] x;
        x = first ^ flip;
        bq[0] = first;
        for (int i = 1; i < 15; i++)
        begin
            bq[i] = 8'($random(seed));
            x ^= bq[i];
        end
        bq[15] = x;
        for (int i = 0; i < 16; i++)
        begin
            if (i == 9)
                cyc(30);
            u_host.send_byte(bq[i]);
        end
    endtask
    task automatic extra(input int k);
        repeat (k) u_host.pulse(1'($random(seed)));
    endtask
    task automatic req_pulse(input int low);
        u_host.set_req(1'b0);
        cyc(4);
        chk(8'({st_oe, dn_oe, ceo_n, ic}), 8'h0E, "request low");
        cyc(low);
        u_host.set_req(1'b1);
        await(st_oe, 1'b0, 80);
        cyc(5 * low);
    endtask
    // System clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Cycles the status pin has been pulled so far
    always @(negedge clk)
        st_hi <= st_oe ? st_hi + 1 : 0;
    // Watchdog
    initial
    begin
        #1000000;
        fails++;
        end_sim;
    end
    // Main sequence
    initial
    begin
        seed = 78209;
        {rst_n, ce_n, uclk, auto, ext, ra} = '0;
        {v40, oth_st, oth_dn} = 3'h7;
        cyc(3);
        chk(8'({st_oe, dn_oe, ic}), 8'h06, "reset");
        rst_n = 1'b1;
        await(st_oe, 1'b0, 100);
        cyc(20);
        oth_dn = 1'b0;
        load(8'hA5, 8'h00);
        await(dn_oe, 1'b0, 20);
        chk(8'(ceo_n), 8'h00, "chain out");
        extra(40);
        chk(8'(ic), 8'h00, "early user");
        for (int i = 0; i < 16; i++)
        begin
            ra = IDX_W'(i);
            cyc(2);
            chk(rd, bq[i], "store");
        end
        oth_dn = 1'b1;
        await(ic, 1'b1, 170);
        chk(8'(n >= 40), 8'h01, "user delay");
        req_pulse(160);
        load(8'h5A, 8'h00);
        cyc(300);
        chk(8'({st_oe, dn_oe}), 8'h03, "error held");
        rst_n = 1'b0;
        {v40, auto, ext} = 3'h3;
        cyc(4);
        rst_n = 1'b1;
        req_pulse(40);
        load(8'hA5, 8'h01);
        await(st_oe, 1'b1, 20);
        await(st_oe, 1'b0, 900);
        chk(8'(st_hi >= min_pulse(v40)), 8'h01, "error pulse");
        cyc(20);
        load(8'hA5, 8'h00);
        await(dn_oe, 1'b0, 20);
        extra(10);
        repeat (9)
        begin
            uclk = 1'b1;
            cyc(3);
            uclk = 1'b0;
            cyc(3);
        end
        chk(8'(ic), 8'h00, "ext startup");
        uclk = 1'b1;
        await(ic, 1'b1, 8);
        ce_n = 1'b1;
        req_pulse(40);
        load(8'hA5, 8'h00);
        cyc(10);
        chk(8'(dn_oe), 8'h01, "not selected");
        ce_n = 1'b0;
        req_pulse(40);
        oth_st = 1'b0;
        load(8'hA5, 8'h00);
        cyc(10);
        chk(8'({dn_oe, st_oe, ceo_n}), 8'h05, "halted");
        end_sim;
    end
endmodule // tb
bind ps_cfg_port ps_cfg_properties u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
    .CONFIG_REQUEST_N(CONFIG_REQUEST_N), .CONFIG_DONE_I(CONFIG_DONE_I),
    .VARIANT_40(VARIANT_40), .STATUS_N_O(STATUS_N_O), .STATUS_N_OE(STATUS_N_OE),
    .CONFIG_DONE_O(CONFIG_DONE_O), .CONFIG_DONE_OE(CONFIG_DONE_OE),
    .CHAIN_ENABLE_OUT_N(CHAIN_ENABLE_OUT_N), .INIT_COMPLETE(INIT_COMPLETE));
`default_nettype wire
